//--- verilog/tvs_pkg.sv
// tvs_pkg: constants and types of the test vector sequencer
// assumes a single 200 MHz clock domain; tester pins are synchronised inside the block
package tvs_pkg;

    // request line codes {line_a, line_b}, each announcing the next vector
    localparam logic [1:0] REQ_ADDR  = 2'b11;
    localparam logic [1:0] REQ_WRITE = 2'b10;
    localparam logic [1:0] REQ_READ  = 2'b01;
    localparam logic [1:0] REQ_EXIT  = 2'b00;

    // control vector field positions
    localparam int CV_VALID   = 0;
    localparam int CV_SIZE_LO = 2;
    localparam int CV_LOCK    = 4;
    localparam int CV_PROT_LO = 5;
    localparam int CV_INCR    = 7;

    // width of the address incrementer in transfer units
    localparam int INC_BITS = 8;

    // transfer attributes after reset
    localparam logic [1:0] SIZE_RST = 2'b10;
    localparam logic [1:0] PROT_RST = 2'b11;
    localparam logic       LOCK_RST = 1'b0;
    localparam logic       INCR_RST = 1'b0;

    // internal bus transfer types
    localparam logic [1:0] TR_IDLE   = 2'b00;
    localparam logic [1:0] TR_NONSEQ = 2'b10;
    localparam logic [1:0] TR_SEQ    = 2'b11;

    // register byte offsets on the software bus
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_ADDR   = 8'h08;
    localparam logic [7:0] REG_BEATS  = 8'h0C;

    // control register reset value and field
    localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
    localparam int          CTRL_EN    = 0;

    // synchroniser reset level
    localparam logic SYNC_RST = 1'b0;

    // internal bus sequencer states
    typedef enum logic [1:0] {
        BS_IDLE = 2'b00,
        BS_ADDR = 2'b01,
        BS_DATA = 2'b10
    } tvs_bus_t;

endpackage : tvs_pkg

//--- verilog/tvs_sync3.sv
// tvs_sync3: three flip-flop synchroniser for inputs from outside the clock domain
// assumes the caller reads only the second and third stages
`timescale 1ns/1ps
module tvs_sync3 #(
    parameter int W = 1
) (
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q_mid,
    output logic      [W-1:0] q_out
);

    logic [W-1:0] s1_reg;

    // three stages in a row; the first feeds only the second
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_reg <= {W{tvs_pkg::SYNC_RST}};
            q_mid  <= {W{tvs_pkg::SYNC_RST}};
            q_out  <= {W{tvs_pkg::SYNC_RST}};
        end else begin
            s1_reg <= d;
            q_mid  <= s1_reg;
            q_out  <= q_mid;
        end
    end

endmodule : tvs_sync3

//--- verilog/tvs_sequencer.sv
// tvs_sequencer: tester vector decode, internal bus transfers and ahb-lite registers
// assumes one 200 MHz clock; tester clock and pins are asynchronous and
// sampled here; the internal bus slave answers with sys_hready
`timescale 1ns/1ps
module tvs_sequencer (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // software register bus
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    // tester pins
    input  wire logic        tester_clock,
    input  wire logic        test_request_line_a,
    input  wire logic        test_request_line_b,
    input  wire logic [31:0] test_data_bus_in,
    output logic      [31:0] test_data_bus_out,
    output logic             test_data_bus_oe,
    output logic             test_acknowledge_out,
    // internal system bus master
    output logic      [31:0] sys_haddr,
    output logic      [1:0]  sys_htrans,
    output logic             sys_hwrite,
    output logic      [2:0]  sys_hsize,
    output logic      [1:0]  sys_hprot,
    output logic             sys_hlock,
    output logic      [31:0] sys_hwdata,
    input  wire logic [31:0] sys_hrdata,
    input  wire logic        sys_hready,
    output logic             sys_test_mode
);

    logic [34:0]        pin_mid;
    logic [34:0]        pin_out;
    logic               tck_lvl_reg;
    logic               tck_edge;
    logic               edge_ok;
    logic [1:0]         req;
    logic [31:0]        din;
    logic               test_mode_reg;
    logic [1:0]         prev_req_reg;
    logic               addr_valid_reg;
    logic               last_addr_reg;
    logic               in_read_reg;
    logic               turn_reg;
    logic               seq_ok_reg;
    logic [31:0]        addr_reg;
    logic [1:0]         size_reg;
    logic [1:0]         prot_reg;
    logic               lock_reg;
    logic               incr_reg;
    logic               launch;
    logic               bus_done;
    logic               busy;
    tvs_pkg::tvs_bus_t  bus_state;
    logic [1:0]         htrans_reg;
    logic               hwrite_reg;
    logic [31:0]        wdata_reg;
    logic [31:0]        dout_reg;
    logic               oe_reg;
    logic [31:0]        beats_reg;
    logic [31:0]        ctrl_reg;
    logic               rd_pend_wr;
    logic [7:0]         wr_off_reg;
    logic [31:0]        next_addr;
    logic               next_wrap;

    // tester clock, request lines and data bus through three flip-flops
    tvs_sync3 #(.W(35)) u_pin_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .d       ({tester_clock, test_request_line_a, test_request_line_b,
                   test_data_bus_in}),
        .q_mid   (pin_mid),
        .q_out   (pin_out)
    );

    assign req = pin_out[33:32];
    assign din = pin_out[31:0];

    // tester clock level follows once stages two and three agree
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tck_lvl_reg <= 1'b0;
        end else if (pin_mid[34] == pin_out[34]) begin
            tck_lvl_reg <= pin_out[34];
        end
    end

    // rising tester edge; ignored while a transfer holds acknowledge low
    assign tck_edge = (pin_mid[34] == pin_out[34]) && pin_out[34] && !tck_lvl_reg;
    assign busy     = (bus_state != tvs_pkg::BS_IDLE);
    assign edge_ok  = tck_edge && test_mode_reg && !busy;

    // a data vector starts an internal transfer only once an address is held
    assign launch = edge_ok && addr_valid_reg &&
                    ((prev_req_reg == tvs_pkg::REQ_WRITE) ||
                     (prev_req_reg == tvs_pkg::REQ_READ));

    // next address from the 8-bit incrementer, scaled by transfer size for sizes 0 to 2 and by 4 bytes for size 3
    always_comb begin
        next_addr = addr_reg;
        next_wrap = 1'b0;
        case (size_reg)
            2'b00: begin
                next_addr[7:0] = addr_reg[7:0] + 8'h01;
                next_wrap      = (addr_reg[7:0] == 8'hFF);
            end
            2'b01: begin
                next_addr[8:1] = addr_reg[8:1] + 8'h01;
                next_wrap      = (addr_reg[8:1] == 8'hFF);
            end
            default: begin
                next_addr[9:2] = addr_reg[9:2] + 8'h01;
                next_wrap      = (addr_reg[9:2] == 8'hFF);
            end
        endcase
    end

    // test mode entry and exit
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            test_mode_reg <= 1'b0;
        end else if (!test_mode_reg) begin
            if (ctrl_reg[tvs_pkg::CTRL_EN] && pin_mid[33] && pin_out[33]) begin
                test_mode_reg <= 1'b1;
            end
        end else if (edge_ok && req == tvs_pkg::REQ_EXIT) begin
            test_mode_reg <= 1'b0;
        end
    end

    // vector classification, address and transfer attributes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev_req_reg   <= tvs_pkg::REQ_EXIT;
            addr_valid_reg <= 1'b0;
            last_addr_reg  <= 1'b0;
            in_read_reg    <= 1'b0;
            turn_reg       <= 1'b0;
            seq_ok_reg     <= 1'b0;
            addr_reg       <= 32'h0000_0000;
            size_reg       <= tvs_pkg::SIZE_RST;
            prot_reg       <= tvs_pkg::PROT_RST;
            lock_reg       <= tvs_pkg::LOCK_RST;
            incr_reg       <= tvs_pkg::INCR_RST;
        end else if (!test_mode_reg) begin
            prev_req_reg   <= tvs_pkg::REQ_EXIT;
            addr_valid_reg <= 1'b0;
            last_addr_reg  <= 1'b0;
            in_read_reg    <= 1'b0;
            turn_reg       <= 1'b0;
        end else if (bus_done) begin
            // advance after each beat while incr_reg is set; a wrap forces the next beat nonsequential
            if (incr_reg) begin
                addr_reg   <= next_addr;
                seq_ok_reg <= !next_wrap;
            end else begin
                seq_ok_reg <= 1'b1;
            end
        end else if (edge_ok) begin
            prev_req_reg <= req;
            case (prev_req_reg)
                tvs_pkg::REQ_ADDR: begin
                    if (in_read_reg) begin
                        // first turnaround after reads
                        in_read_reg   <= 1'b0;
                        turn_reg      <= 1'b1;
                        last_addr_reg <= 1'b0;
                    end else if (turn_reg) begin
                        // second turnaround; address is kept
                        turn_reg      <= 1'b0;
                    end else if (last_addr_reg && req != tvs_pkg::REQ_ADDR) begin
                        // control vector directly after an address
                        last_addr_reg <= 1'b0;
                        if (din[tvs_pkg::CV_VALID]) begin
                            size_reg   <= din[tvs_pkg::CV_SIZE_LO +: 2];
                            lock_reg   <= din[tvs_pkg::CV_LOCK];
                            prot_reg   <= din[tvs_pkg::CV_PROT_LO +: 2];
                            incr_reg   <= din[tvs_pkg::CV_INCR];
                            seq_ok_reg <= 1'b0;
                        end else begin
                            // attributes unchanged, so the next beat continues the burst
                            seq_ok_reg <= 1'b1;
                        end
                    end else begin
                        // address vector, shown on the internal bus at once
                        addr_reg       <= din;
                        addr_valid_reg <= 1'b1;
                        last_addr_reg  <= 1'b1;
                        seq_ok_reg     <= 1'b0;
                    end
                end
                tvs_pkg::REQ_READ: begin
                    last_addr_reg <= 1'b0;
                    turn_reg      <= 1'b0;
                    in_read_reg   <= addr_valid_reg;
                end
                tvs_pkg::REQ_WRITE: begin
                    last_addr_reg <= 1'b0;
                    turn_reg      <= 1'b0;
                end
                default: begin
                    last_addr_reg <= 1'b0;
                end
            endcase
        end
    end

    // internal bus sequencer: address phase, then data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_state  <= tvs_pkg::BS_IDLE;
            htrans_reg <= tvs_pkg::TR_IDLE;
            hwrite_reg <= 1'b0;
            wdata_reg  <= 32'h0000_0000;
        end else begin
            case (bus_state)
                tvs_pkg::BS_IDLE: begin
                    if (launch) begin
                        bus_state  <= tvs_pkg::BS_ADDR;
                        htrans_reg <= seq_ok_reg ? tvs_pkg::TR_SEQ
                                                 : tvs_pkg::TR_NONSEQ;
                        hwrite_reg <= (prev_req_reg == tvs_pkg::REQ_WRITE);
                        wdata_reg  <= din;
                    end
                end
                tvs_pkg::BS_ADDR: begin
                    if (sys_hready) begin
                        bus_state  <= tvs_pkg::BS_DATA;
                        htrans_reg <= tvs_pkg::TR_IDLE;
                    end
                end
                tvs_pkg::BS_DATA: begin
                    if (sys_hready) begin
                        bus_state <= tvs_pkg::BS_IDLE;
                    end
                end
                default: begin
                    bus_state <= tvs_pkg::BS_IDLE;
                end
            endcase
        end
    end

    assign bus_done = (bus_state == tvs_pkg::BS_DATA) && sys_hready;

    // read data return and tester bus drivers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dout_reg <= 32'h0000_0000;
            oe_reg   <= 1'b0;
        end else if (!test_mode_reg) begin
            oe_reg <= 1'b0;
        end else if (edge_ok && req != tvs_pkg::REQ_READ) begin
            oe_reg <= 1'b0;
        end else if (bus_done && !hwrite_reg) begin
            dout_reg <= sys_hrdata;
            oe_reg   <= (prev_req_reg == tvs_pkg::REQ_READ);
        end
    end

    // count of completed internal beats
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            beats_reg <= 32'h0000_0000;
        end else if (bus_done) begin
            beats_reg <= beats_reg + 32'h0000_0001;
        end
    end

    // tester and internal bus outputs
    assign test_data_bus_out    = dout_reg;
    assign test_data_bus_oe     = oe_reg;
    assign test_acknowledge_out = test_mode_reg && !busy;
    assign sys_haddr            = addr_reg;
    assign sys_htrans           = htrans_reg;
    assign sys_hwrite           = hwrite_reg;
    assign sys_hsize            = {1'b0, size_reg};
    assign sys_hprot            = prot_reg;
    assign sys_hlock            = lock_reg;
    assign sys_hwdata           = wdata_reg;
    assign sys_test_mode        = test_mode_reg;

    // ahb-lite slave: zero wait states, always okay
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // address phase: capture writes, prepare read data
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_pend_wr <= 1'b0;
            wr_off_reg <= 8'h00;
            hrdata     <= 32'h0000_0000;
        end else if (hready) begin
            rd_pend_wr <= hsel && htrans[1] && hwrite;
            wr_off_reg <= haddr[7:0];
            if (hsel && htrans[1] && !hwrite) begin
                if (haddr[7:0] == tvs_pkg::REG_CTRL) begin
                    hrdata <= ctrl_reg;
                end else if (haddr[7:0] == tvs_pkg::REG_STATUS) begin
                    hrdata <= {22'h00_0000, incr_reg, prot_reg, lock_reg, size_reg,
                               oe_reg, addr_valid_reg, busy, test_mode_reg};
                end else if (haddr[7:0] == tvs_pkg::REG_ADDR) begin
                    hrdata <= addr_reg;
                end else if (haddr[7:0] == tvs_pkg::REG_BEATS) begin
                    hrdata <= beats_reg;
                end else begin
                    hrdata <= 32'h0000_0000;
                end
            end
        end
    end

    // data phase: control register write, only the enable bit is kept
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg <= tvs_pkg::CTRL_RST;
        end else if (rd_pend_wr && wr_off_reg == tvs_pkg::REG_CTRL) begin
            ctrl_reg <= {31'h0000_0000, hwdata[tvs_pkg::CTRL_EN]};
        end
    end

endmodule : tvs_sequencer

//--- verif/tvs_seq_assertions.sv
// tvs_seq_assertions: port-level checks of the test vector sequencer
// assumes one hclk domain with hresetn asynchronous and active low
`timescale 1ns/1ps
module tvs_seq_checker (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        test_data_bus_oe,
    input wire logic        test_acknowledge_out,
    input wire logic [31:0] sys_haddr,
    input wire logic [1:0]  sys_htrans,
    input wire logic        sys_hwrite,
    input wire logic [2:0]  sys_hsize,
    input wire logic        sys_hready,
    input wire logic        sys_test_mode
);
    logic [31:0] last_addr_reg;
    logic [9:0]  bound_mask;
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // address of the last beat accepted on the internal bus
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            last_addr_reg <= 32'h0000_0000;
        end else if (sys_htrans[1] && sys_hready) begin
            last_addr_reg <= sys_haddr;
        end
    end
    // address bits covered by the incrementer for sizes 0 to 2; for size 3 bits 9:3, while it covers 9:2
    assign bound_mask = 10'h0FF << sys_hsize[1:0];
    ack_mode_a: assert property (test_acknowledge_out |-> sys_test_mode)
        else $error("ack high outside test mode");
    ack_busy_a: assert property (sys_htrans != tvs_pkg::TR_IDLE |-> !test_acknowledge_out)
        else $error("ack high during an internal transfer");
    stall_hold_a: assert property (sys_htrans[1] && !sys_hready |=>
        $stable(sys_haddr) && $stable(sys_htrans)) else $error("address phase not held");
    beat_single_a: assert property (sys_htrans[1] && sys_hready |=>
        sys_htrans == tvs_pkg::TR_IDLE) else $error("more than one beat per vector");
    oe_mode_a: assert property (test_data_bus_oe |-> sys_test_mode)
        else $error("data bus driven outside test mode");
    oe_read_a: assert property ($rose(test_data_bus_oe) |-> !sys_hwrite)
        else $error("data bus driven after a write");
    wrap_nonseq_a: assert property (sys_htrans == tvs_pkg::TR_SEQ && sys_hready &&
        sys_haddr != last_addr_reg |-> (sys_haddr[9:0] & bound_mask) != 10'h000)
        else $error("sequential beat across the incrementer boundary");
    exit_idle_a: assert property ($fell(sys_test_mode) |->
        sys_htrans == tvs_pkg::TR_IDLE && !test_data_bus_oe) else $error("exit while busy");
    cover property (sys_htrans == tvs_pkg::TR_SEQ && sys_hready && sys_hwrite);
    cover property ($rose(test_data_bus_oe));
    cover property ($fell(sys_test_mode));
endmodule : tvs_seq_checker

bind tvs_sequencer tvs_seq_checker tvs_seq_checker_inst (.hclk, .hresetn, .test_data_bus_oe,
    .test_acknowledge_out, .sys_haddr, .sys_htrans, .sys_hwrite, .sys_hsize, .sys_hready,
    .sys_test_mode);

//--- verif/tvs_tester_model.sv
// tvs_tester_model: tester side of the vector link, makes the tester clock
// assumes the bench resolves the data bus from the device's enable
`timescale 1ns/1ps
module tvs_tester_model (
    output logic        tester_clock,
    output logic        test_request_line_a,
    output logic        test_request_line_b,
    output logic [31:0] drive_data,
    output logic        drive_en,
    input  wire logic   test_acknowledge_out
);
    logic [31:0] last_data;
    // idle pins: clock still, lines low, bus parked
    initial begin
        tester_clock = 1'b0;
        {test_request_line_a, test_request_line_b} = 2'b00;
        drive_data = 32'h0000_0000;
        drive_en = 1'b0;
        last_data = 32'h0000_0000;
    end
    // ask for the internal bus
    task automatic enter();
        {test_request_line_a, test_request_line_b} = 2'b10;
    endtask : enter
    // one vector: this vector's data with the code of the next one
    task automatic vec(input logic [1:0] code, input logic [31:0] data, input logic drv);
        {test_request_line_a, test_request_line_b} = code;
        if (drv) begin
            last_data = data;
        end
        drive_en = drv;
        drive_data = drv ? data : ~last_data;
        #80;
        // hold the vector until acknowledged; a hang is ended by the bench watchdog
        while (!test_acknowledge_out) begin
            #5;
        end
        tester_clock = 1'b1;
        #80;
        tester_clock = 1'b0;
    endtask : vec
endmodule : tvs_tester_model

//--- verif/tvs_sequencer_bench.sv
// tvs_sequencer_bench: register bus, tester vectors and internal bus checks
// assumes the tester model drives vectors and this bench plays the internal slave
`timescale 1ns/1ps
module tvs_sequencer_bench;
    localparam logic [31:0] RDATA = 32'h5A3C_96E1;
    logic        hclk, hresetn, hready, hreadyout, hresp;
    logic        hsel = 1'b0, hwrite = 1'b0, sys_hready = 1'b1, pend = 1'b0;
    logic [1:0]  htrans = 2'b00;
    logic [2:0]  hsize = 3'b010;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000;
    logic [31:0] hrdata, test_data_bus_in, test_data_bus_out, drive_data, rd;
    logic        tester_clock, test_request_line_a, test_request_line_b, drive_en;
    logic        test_data_bus_oe, test_acknowledge_out, sys_hwrite, sys_hlock, sys_test_mode;
    logic [31:0] sys_haddr, sys_hwdata;
    logic [1:0]  sys_htrans, sys_hprot;
    logic [2:0]  sys_hsize;
    logic [34:0] tq[$];
    logic [31:0] dq[$];
    int          bad_count = 0, n_checks = 0, cyc = 0;
    wire  [31:0] sys_hrdata = RDATA;
    // data bus level: the device's drive, else the tester's or its parked value
    assign test_data_bus_in = test_data_bus_oe ? test_data_bus_out : drive_data;
    assign hready = hreadyout;
    tvs_sequencer tvs_sequencer_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready, .hreadyout, .hresp, .hrdata, .tester_clock, .test_request_line_a,
        .test_request_line_b, .test_data_bus_in, .test_data_bus_out, .test_data_bus_oe,
        .test_acknowledge_out, .sys_haddr, .sys_htrans, .sys_hwrite, .sys_hsize, .sys_hprot,
        .sys_hlock, .sys_hwdata, .sys_hrdata, .sys_hready, .sys_test_mode);
    tvs_tester_model tvs_tester_model_inst (.tester_clock, .test_request_line_a,
        .test_request_line_b, .drive_data, .drive_en, .test_acknowledge_out);
    // 200 MHz clock
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end
    // internal slave waits one cycle in three; log beats and write data, watch for bus clash
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        sys_hready <= (cyc % 3) != 2;
        if (pend && sys_hready) begin
            dq.push_back(sys_hwdata);
            pend = 1'b0;
        end
        if (sys_htrans[1] && sys_hready) begin
            tq.push_back({sys_htrans, sys_hwrite, sys_haddr});
            pend = sys_hwrite;
        end
        if (drive_en && test_data_bus_oe) begin
            chk(35'h1, 35'h0, "both sides drive the data bus");
        end
    end
    // count a comparison and report a mismatch
    task automatic chk(input logic [34:0] got, input logic [34:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    // next logged beat: type, direction, address and write data
    task automatic beat(input logic [1:0] tr, input logic wr, input logic [31:0] a,
                        input logic [31:0] d);
        chk(tq.size() > 0 ? tq.pop_front() : 35'h0, {tr, wr, a}, "beat");
        if (wr) begin
            chk(dq.size() > 0 ? dq.pop_front() : ~d, d, "write data");
        end
    endtask : beat
    // one single word transfer on the register bus
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h00_0000, a};
        hwrite <= wr;
        do @(posedge hclk); while (!hready);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (!hready);
        rd = hrdata;
    endtask : ahb
    // address, optional control, then n writes; the last announces an address
    task automatic wburst(input logic [31:0] a, input logic [31:0] ctl, input logic c, input int n);
        tvs_tester_model_inst.vec(c ? tvs_pkg::REQ_ADDR : tvs_pkg::REQ_WRITE, a, 1'b1);
        if (c) begin
            tvs_tester_model_inst.vec(tvs_pkg::REQ_WRITE, ctl, 1'b1);
        end
        chk(sys_haddr, a, "internal address");
        for (int i = 0; i < n; i++) begin
            tvs_tester_model_inst.vec(i == n - 1 ? tvs_pkg::REQ_ADDR : tvs_pkg::REQ_WRITE,
                                      a + i, 1'b1);
        end
    endtask : wburst
    // verdict
    task automatic end_sim();
        $display("checks %0d, mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_sim
    // watchdog
    initial begin
        #100_000;
        bad_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        end_sim();
    end
    // main sequence
    initial begin
        hresetn = 1'b0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        #1;
        chk({hreadyout, hresp, sys_hsize, sys_hprot, sys_htrans, test_acknowledge_out},
            {2'b10, 1'b0, tvs_pkg::SIZE_RST, tvs_pkg::PROT_RST, 3'b000}, "reset outputs");
        ahb(1'b0, tvs_pkg::REG_CTRL, 32'h0000_0000);
        chk(rd, tvs_pkg::CTRL_RST, "ctrl reset");
        ahb(1'b0, 8'h40, 32'h0000_0000);
        chk(rd, 32'h0000_0000, "unmapped read");
        ahb(1'b1, tvs_pkg::REG_CTRL, 32'h0000_0001);
        ahb(1'b0, tvs_pkg::REG_CTRL, 32'h0000_0000);
        chk(rd, 32'h0000_0001, "ctrl enable");
        tvs_tester_model_inst.enter();
        repeat (40) if (!test_acknowledge_out) @(posedge hclk);
        chk(sys_test_mode, 1'b1, "test mode entry");
        tvs_tester_model_inst.vec(tvs_pkg::REQ_ADDR, 32'h0000_0000, 1'b1);
        wburst(32'h0000_2010, 32'h0000_0000, 1'b0, 1);
        beat(tvs_pkg::TR_NONSEQ, 1'b1, 32'h0000_2010, 32'h0000_2010);
        wburst(32'h0000_13F8, 32'h0000_00B9, 1'b1, 3);
        chk({sys_hlock, sys_hprot, sys_hsize}, 6'b101_010, "attributes");
        beat(tvs_pkg::TR_NONSEQ, 1'b1, 32'h0000_13F8, 32'h0000_13F8);
        beat(tvs_pkg::TR_SEQ, 1'b1, 32'h0000_13FC, 32'h0000_13F9);
        beat(tvs_pkg::TR_NONSEQ, 1'b1, 32'h0000_1000, 32'h0000_13FA);
        wburst(32'h0000_2224, 32'h0000_0004, 1'b1, 2);
        chk({sys_hlock, sys_hprot, sys_hsize}, 6'b101_010, "kept attributes");
        beat(tvs_pkg::TR_SEQ, 1'b1, 32'h0000_2224, 32'h0000_2224);
        beat(tvs_pkg::TR_SEQ, 1'b1, 32'h0000_2228, 32'h0000_2225);
        wburst(32'h0000_3300, 32'h0000_0009, 1'b1, 3);
        chk({sys_hlock, sys_hprot, sys_hsize}, 6'b000_010, "new attributes");
        for (int i = 0; i < 3; i++) begin
            beat(i == 0 ? tvs_pkg::TR_NONSEQ : tvs_pkg::TR_SEQ, 1'b1, 32'h0000_3300,
                 32'h0000_3300 + i);
        end
        tvs_tester_model_inst.vec(tvs_pkg::REQ_READ, 32'h0000_4440, 1'b1);
        chk(test_data_bus_oe, 1'b0, "bus free before read");
        tvs_tester_model_inst.vec(tvs_pkg::REQ_READ, 32'h0000_0000, 1'b0);
        chk({test_data_bus_oe, test_data_bus_out}, {1'b1, RDATA}, "read data");
        tvs_tester_model_inst.vec(tvs_pkg::REQ_ADDR, 32'h0000_0000, 1'b0);
        chk(test_data_bus_oe, 1'b0, "driver off after reads");
        tvs_tester_model_inst.vec(tvs_pkg::REQ_ADDR, 32'h0000_0000, 1'b0);
        tvs_tester_model_inst.vec(tvs_pkg::REQ_WRITE, 32'h0000_0000, 1'b0);
        tvs_tester_model_inst.vec(tvs_pkg::REQ_ADDR, 32'h0000_5555, 1'b1);
        beat(tvs_pkg::TR_NONSEQ, 1'b0, 32'h0000_4440, 32'h0000_0000);
        beat(tvs_pkg::TR_SEQ, 1'b0, 32'h0000_4440, 32'h0000_0000);
        beat(tvs_pkg::TR_SEQ, 1'b1, 32'h0000_4440, 32'h0000_5555);
        tvs_tester_model_inst.vec(tvs_pkg::REQ_EXIT, 32'h0000_4440, 1'b1);
        chk({test_acknowledge_out, sys_test_mode, 32'(tq.size())}, 34'h0, "exit");
        ahb(1'b0, tvs_pkg::REG_STATUS, 32'h0000_0000);
        chk(rd, 32'h0000_0020, "status after exit");
        ahb(1'b0, tvs_pkg::REG_BEATS, 32'h0000_0000);
        chk(rd, 32'h0000_000C, "beat count");
        ahb(1'b0, tvs_pkg::REG_ADDR, 32'h0000_0000);
        chk(rd, 32'h0000_4440, "held address");
        end_sim();
    end
endmodule : tvs_sequencer_bench
